// ---- hdl/nvm_array.sv ----
// small memory model of the three nvm regions, registered read data
`timescale 1ns/1ps
module nvm_array
   import nvm_pkg::*;
(
   input wire logic pclk,
   input wire logic mem_go,
   input wire mem_req_t mem_req,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [3*mem_depth];
   logic [9:0] idx;

   // region picks a bank of the array
   assign idx = {mem_req.sel, mem_req.addr};

   // ==========================================================
   // write or read on go; no reset so content survives
   always_ff @(posedge pclk) begin
      if (mem_go && mem_req.we) begin
         mem[idx] <= mem_req.wdata;
      end
      if (mem_go) begin
         mem_rdata <= mem[idx];
      end
   end
endmodule : nvm_array

// ---- hdl/nvm_control_sequencer.sv ----
// nvm control sequencer: apb registers, unlock, self-timed read/write
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module nvm_control_sequencer
   import nvm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   seq_state_t state_r, state_nxt;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [addr_w-1:0] nvm_address_r, nvm_address_nxt;
   logic [7:0] nvm_read_data_r, nvm_read_data_nxt;
   logic [7:0] hold_r, hold_nxt;
   logic [1:0] unlock_r, unlock_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [irq_w-1:0] stat_r, stat_nxt, en_r, en_nxt;
   logic wr_access, rd_access, hit, mem_go;
   logic [7:0] wb;
   logic [7:0] mem_rdata;
   mem_req_t mem_req;
   target_t tgt;

   // ==========================================================
   // apb decode
   assign wr_access = psel && penable && pwrite;
   assign rd_access = psel && penable && !pwrite;
   assign wb = pwdata[7:0];
   assign pready = 1'b1;
   assign hit = (paddr == off_ctrl) || (paddr == off_addr) ||
                (paddr == off_rdata) || (paddr == off_wdata) ||
                (paddr == off_unlock) || (paddr == off_irq_stat) ||
                (paddr == off_irq_en) || (paddr == off_irq_clr);
   assign pslverr = psel && penable && !hit;
   assign tgt = decode_region(ctrl_r[b_reg_lo+1:b_reg_lo]);
   assign irq = |(stat_r & en_r);

   // read mux
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_access) begin
         case (paddr)
            off_ctrl: prdata = {24'h00_0000, ctrl_r};
            off_addr: prdata = {24'h00_0000, nvm_address_r};
            off_rdata: prdata = {24'h00_0000, nvm_read_data_r};
            off_wdata: prdata = {24'h00_0000, hold_r};
            off_irq_stat: prdata = {29'h0000_0000, stat_r};
            off_irq_en: prdata = {29'h0000_0000, en_r};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   // memory request from current registers
   always_comb begin
      mem_req.we = (state_r == st_write) && (cnt_r == 16'h0001);
      mem_req.sel = tgt;
      mem_req.addr = nvm_address_r;
      mem_req.wdata = ctrl_r[b_erase] ? 8'hff : hold_r;
      mem_go = ((state_r == st_read) || (state_r == st_write)) &&
               (cnt_r == 16'h0001);
   end

   // ==========================================================
   // sequencer and register next state
   always_comb begin
      state_nxt = state_r;
      ctrl_nxt = ctrl_r;
      nvm_address_nxt = nvm_address_r;
      nvm_read_data_nxt = nvm_read_data_r;
      hold_nxt = hold_r;
      unlock_nxt = unlock_r;
      cnt_nxt = cnt_r;
      stat_nxt = stat_r;
      en_nxt = en_r;
      if (cnt_r != 16'h0000) begin
         cnt_nxt = cnt_r - 16'h0001;
      end
      if (wr_access) begin
         case (paddr)
            off_ctrl: begin
               // plain fields; error only cleared by sw zero
               ctrl_nxt = (ctrl_r & ~ctrl_wmask) | (wb & ctrl_wmask);
               ctrl_nxt[b_err] = ctrl_r[b_err] & wb[b_err];
               if (wb[b_rd] && state_r == st_idle) begin
                  ctrl_nxt[b_rd] = 1'b1;
                  state_nxt = st_read;
                  cnt_nxt = 16'(read_cyc);
               end
               if (wb[b_wr] && state_r == st_idle) begin
                  if (unlock_r == 2'h2 && ctrl_r[b_en]) begin
                     ctrl_nxt[b_wr] = 1'b1;
                     state_nxt = st_write;
                     cnt_nxt = 16'(write_cyc);
                  end
               end
               unlock_nxt = 2'h0;
            end
            off_addr: nvm_address_nxt = wb;
            off_wdata: hold_nxt = wb;
            off_unlock: begin
               if (wb == key_one) begin
                  unlock_nxt = 2'h1;
               end else if (wb == key_two && unlock_r == 2'h1) begin
                  unlock_nxt = 2'h2;
               end else begin
                  unlock_nxt = 2'h0;
               end
            end
            off_irq_en: en_nxt = wb[irq_w-1:0];
            off_irq_clr: stat_nxt = stat_r & ~wb[irq_w-1:0];
            default: begin
               unlock_nxt = 2'h0;
            end
         endcase
      end
      // completion; hardware set wins over clears above
      case (state_r)
         st_read: begin
            if (cnt_r == 16'h0000) begin
               nvm_read_data_nxt = mem_rdata;
               ctrl_nxt[b_rd] = 1'b0;
               stat_nxt[0] = 1'b1;
               state_nxt = st_idle;
            end
         end
         st_write: begin
            ctrl_nxt[b_wr] = 1'b1;
            if (cnt_r == 16'h0000) begin
               ctrl_nxt[b_wr] = 1'b0;
               stat_nxt[1] = 1'b1;
               state_nxt = st_idle;
            end
         end
         st_idle: ;
         default: state_nxt = st_idle;
      endcase
      // write to the config region flags an error; the array cell is still written
      if (state_r == st_write && cnt_r == 16'h0000 &&
          tgt == tgt_config) begin
         ctrl_nxt[b_err] = 1'b1;
         stat_nxt[2] = 1'b1;
      end
   end

   // register all state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= st_idle;
         ctrl_r <= ctrl_rst;
         nvm_address_r <= 8'h00;
         nvm_read_data_r <= 8'h00;
         hold_r <= 8'h00;
         unlock_r <= 2'h0;
         cnt_r <= 16'h0000;
         stat_r <= 3'h0;
         en_r <= 3'h0;
      end else begin
         state_r <= state_nxt;
         ctrl_r <= ctrl_nxt;
         nvm_address_r <= nvm_address_nxt;
         nvm_read_data_r <= nvm_read_data_nxt;
         hold_r <= hold_nxt;
         unlock_r <= unlock_nxt;
         cnt_r <= cnt_nxt;
         stat_r <= stat_nxt;
         en_r <= en_nxt;
      end
   end

   nvm_array u_array (
      .pclk(pclk),
      .mem_go(mem_go),
      .mem_req(mem_req),
      .mem_rdata(mem_rdata)
   );

   // ==========================================================
   // assertions
   a_wr_needs_unlock: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ctrl_r[b_wr]) |-> $past(unlock_r) == 2'h2)
      else $error("write started without unlock");
   a_wr_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == st_write && cnt_r > 16'h0000) |=> ctrl_r[b_wr])
      else $error("write start cleared early");
   a_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(ctrl_r[b_err]) |-> $past(wr_access && paddr == off_ctrl))
      else $error("error flag cleared by hardware");
   a_rd_done: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ctrl_r[b_rd]) |-> ##[1:4] !ctrl_r[b_rd])
      else $error("read start not cleared");
   a_rd_load: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(ctrl_r[b_rd]) |-> nvm_read_data_r == $past(mem_rdata))
      else $error("read data not loaded");
   a_wr_done: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ctrl_r[b_wr]) |-> ##[1:25] !ctrl_r[b_wr])
      else $error("write did not finish");
   a_wr_data: assert property (@(posedge pclk) disable iff (!presetn)
      mem_req.we |-> mem_req.wdata ==
      (ctrl_r[b_erase] ? 8'hff : hold_r))
      else $error("wrong write data");
   a_region: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_r[b_reg_lo] |-> tgt == tgt_config)
      else $error("region decode wrong");
   c_read: cover property (@(posedge pclk) $fell(ctrl_r[b_rd]));
   c_write: cover property (@(posedge pclk) $fell(ctrl_r[b_wr]));
   c_err: cover property (@(posedge pclk) $rose(ctrl_r[b_err]));
endmodule : nvm_control_sequencer

// ---- hdl/nvm_pkg.sv ----
// package of constants and types for the nvm control sequencer
package nvm_pkg;
   // ==========================================================
   // register map, byte offsets on apb
   localparam logic [7:0] off_ctrl = 8'h00;
   localparam logic [7:0] off_addr = 8'h04;
   localparam logic [7:0] off_rdata = 8'h08;
   localparam logic [7:0] off_wdata = 8'h0c;
   localparam logic [7:0] off_unlock = 8'h10;
   localparam logic [7:0] off_irq_stat = 8'h14;
   localparam logic [7:0] off_irq_en = 8'h18;
   localparam logic [7:0] off_irq_clr = 8'h1c;
   // ==========================================================
   // control register field positions
   localparam int b_rd = 0;
   localparam int b_wr = 1;
   localparam int b_en = 2;
   localparam int b_err = 3;
   localparam int b_erase = 4;
   localparam int b_reg_lo = 6;
   localparam logic [7:0] ctrl_rst = 8'h00;
   localparam logic [7:0] ctrl_wmask = 8'hdc; // region, erase, err, enable
   // ==========================================================
   // unlock keys and region codes
   localparam logic [7:0] key_one = 8'h55;
   localparam logic [7:0] key_two = 8'haa;
   localparam logic [1:0] reg_eeprom = 2'h0;
   localparam logic [1:0] reg_flash = 2'h2;
   // ==========================================================
   // timing
   localparam int clk_ns = 100;
   localparam int read_ns = 200;
   localparam int write_ns = 2000;
   localparam int read_cyc = (read_ns + clk_ns - 1) / clk_ns;
   localparam int write_cyc = (write_ns + clk_ns - 1) / clk_ns;
   localparam int addr_w = 8;
   localparam int mem_depth = 256;
   // irq bits: 0 read done, 1 write done, 2 write error
   localparam int irq_w = 3;
   // ==========================================================
   // region decode
   typedef enum logic [1:0] {tgt_eeprom, tgt_flash, tgt_config} target_t;
   typedef struct packed {
      logic we;
      logic [1:0] sel;
      logic [addr_w-1:0] addr;
      logic [7:0] wdata;
   } mem_req_t;
   typedef enum {st_idle, st_read, st_write} seq_state_t;

   function automatic target_t decode_region(input logic [1:0] r);
      if (r[0]) begin
         decode_region = tgt_config;
      end else if (r == reg_flash) begin
         decode_region = tgt_flash;
      end else begin
         decode_region = tgt_eeprom;
      end
   endfunction : decode_region
endpackage : nvm_pkg

// ---- verification/nvm_store_model.sv ----
// far side store model: expected contents of the nvm regions
`timescale 1ns/1ps
module nvm_store_model;
   int mem[int];
   // ==========================================================
   // program or erase one cell, keyed by region and address
   function automatic void put(input int k, input int d);
      mem[k] = d & 32'hff;
   endfunction : put
   // unwritten cells read as erased
   function automatic int get(input int k);
      return mem.exists(k) ? mem[k] : 32'hff;
   endfunction : get
endmodule : nvm_store_model

// ---- verification/tb_top.sv ----
// self-checking bench of the nvm control sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top
   import nvm_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0] paddr, a, d, c;
   logic [31:0] pwdata, prdata, q;
   integer seed;
   int fail_count, cmp_count;
   nvm_control_sequencer nvm_control_sequencer_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq));
   nvm_store_model nvm_store_model_i ();
   // ==========================================================
   // clock and watchdog
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      #(100 * 20000);
      fail_count++;
      report_and_stop();
   end
   // ==========================================================
   // apb master: setup, access until pready, one idle cycle
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] wd);
      logic rdy;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // answer taken at the rising edge that completes the access
      do begin
         @(posedge pclk);
         rdy = pready;
         q = prdata;
         err = pslverr;
      end while (rdy !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
      apb(1'b1, ad, {24'h0, wd});
   endtask : wr
   // poll a control bit until hardware clears it
   task automatic wait_idle(input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, off_ctrl, 32'h0);
         n++;
      end while (q[b] !== 1'b0 && n < 100);
      `CHK("busy_clear", 1'b0, q[b])
   endtask : wait_idle
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   // unlocked start of a write with control value cv
   task automatic start_write(input logic [7:0] cv);
      wr(off_ctrl, cv);
      wr(off_unlock, key_one);
      wr(off_unlock, key_two);
      wr(off_ctrl, cv | 8'h02);
   endtask : start_write
   // ==========================================================
   // main sequence
   initial begin
      seed = 63423;
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fail_count = 0;
      cmp_count = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, off_ctrl, 32'h0);
      `CHK("ctrl_reset", ctrl_rst, q[7:0])
      apb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped", 1'b1, err)
      wr(off_ctrl, 8'h86);
      apb(1'b0, off_ctrl, 32'h0);
      `CHK("no_unlock", 1'b0, q[b_wr])
      // flash write, flash erase, eeprom write, then read back
      for (int i = 0; i < 3; i++) begin
         a = 8'($random(seed));
         d = 8'($random(seed));
         c = (i == 2) ? 8'h04 : ((i == 1) ? 8'h94 : 8'h84);
         wr(off_addr, a);
         wr(off_wdata, d);
         start_write(c);
         wr(off_ctrl, c);
         apb(1'b0, off_ctrl, 32'h0);
         `CHK("wr_held", 1'b1, q[b_wr])
         nvm_store_model_i.put({c[7:6], a}, (i == 1) ? 32'hff : d);
         wait_idle(b_wr);
         wr(off_ctrl, (c & 8'hef) | 8'h01);
         wait_idle(b_rd);
         apb(1'b0, off_rdata, 32'h0);
         `CHK("rdata", 8'(nvm_store_model_i.get({c[7:6], a})), q[7:0])
      end
      // writes to either config code end in the error flag
      for (int j = 0; j < 2; j++) begin
         start_write(j ? 8'hc4 : 8'h44);
         wait_idle(b_wr);
         wr(off_ctrl, 8'h4c);
         apb(1'b0, off_ctrl, 32'h0);
         `CHK("err_sticky", 1'b1, q[b_err])
         wr(off_ctrl, 8'h00);
         apb(1'b0, off_ctrl, 32'h0);
         `CHK("err_clear", 1'b0, q[b_err])
      end
      // interrupt status, enable, mask and clear
      apb(1'b0, off_irq_stat, 32'h0);
      `CHK("irq_stat", 3'h7, q[2:0])
      `CHK("irq_off", 1'b0, irq)
      wr(off_irq_en, 8'h07);
      `CHK("irq_on", 1'b1, irq)
      wr(off_irq_clr, 8'h03);
      apb(1'b0, off_irq_stat, 32'h0);
      `CHK("irq_clr", 3'h4, q[2:0])
      wr(off_irq_en, 8'h03);
      `CHK("irq_mask", 1'b0, irq)
      wr(off_irq_clr, 8'h04);
      apb(1'b0, off_irq_stat, 32'h0);
      `CHK("irq_empty", 3'h0, q[2:0])
      report_and_stop();
   end
endmodule : tb_top
